// file: verilog/spi_port_pkg.sv
package spi_port_pkg;
   // =====================================================
   // Register byte addresses
   localparam logic [7:0] ADR_STATUS = 8'h00;
   localparam logic [7:0] ADR_CTRL1  = 8'h04;
   localparam logic [7:0] ADR_CTRL3  = 8'h08;
   localparam logic [7:0] ADR_BUF    = 8'h0C;
   localparam logic [7:0] ADR_RELOAD = 8'h10;
   localparam logic [7:0] ADR_FLAGS  = 8'h14;

   // =====================================================
   // Field positions
   localparam int ST_SMP  = 7;
   localparam int ST_CKE  = 6;
   localparam int ST_BF   = 0;
   localparam int C1_WRITE_COLLISION_FLAG = 7;
   localparam int C1_OV   = 6;
   localparam int C1_EN   = 5;
   localparam int C1_CKP  = 4;
   localparam int C3_BUFFER_OVERWRITE_ENABLE = 4;
   localparam int FL_IRQ  = 0;

   // =====================================================
   // Port mode codes, low nibble of control one
   localparam logic [3:0] MODE_DIV4   = 4'h0;
   localparam logic [3:0] MODE_DIV16  = 4'h1;
   localparam logic [3:0] MODE_DIV64  = 4'h2;
   localparam logic [3:0] MODE_TMR    = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV    = 4'h5;
   localparam logic [3:0] MODE_RELOAD = 4'hA;

   // =====================================================
   // Timing: half serial clock periods in core clocks
   localparam int         DIV_W      = 10;
   localparam logic [9:0] HALF_DIV4  = 10'h002;
   localparam logic [9:0] HALF_DIV16 = 10'h008;
   localparam logic [9:0] HALF_DIV64 = 10'h020;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [3:0] BYTE_BITS  = 4'h8;

   // =====================================================
   // Reset values
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_CTRL1  = 8'h00;
   localparam logic [7:0] RST_CTRL3  = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;

   typedef enum logic [1:0] {
      M_IDLE  = 2'b00,
      M_LEAD  = 2'b01,
      M_TRAIL = 2'b11,
      M_TAIL  = 2'b10
   } mstate_t;
endpackage : spi_port_pkg

// file: verilog/spi_baud_gen.sv
`timescale 1ns/1ns
module spi_baud_gen
   import spi_port_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_run,
   input  wire logic [3:0] i_rate_sel,
   input  wire logic [7:0] i_reload,
   input  wire logic       i_timer_tick,
   output logic            o_tick
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } baud_t;

   baud_t q;
   baud_t n;
   logic [DIV_W-1:0] half;

   // R13 rate select
   function automatic logic [DIV_W-1:0] half_len(input logic [3:0] sel, input logic [7:0] rl);
      unique case (sel)
         MODE_DIV16:  half_len = HALF_DIV16;
         MODE_DIV64:  half_len = HALF_DIV64;
         MODE_RELOAD: half_len = {1'b0, rl, 1'b0} + {DIV_W{1'b0}} + HALF_DIV4;
         default:     half_len = HALF_DIV4;
      endcase
   endfunction : half_len

   always_comb begin
      n      = q;
      half   = half_len(i_rate_sel, i_reload);
      n.tick = 1'b0;
      if (!i_run) begin
         n.cnt = '0;
      end else if (i_rate_sel == MODE_TMR) begin
         // Each timer pulse is one half period: clock is timer rate over two
         n.tick = i_timer_tick;
      end else if (q.cnt >= half - 10'h001) begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 10'h001;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_tick = q.tick;
endmodule : spi_baud_gen

// file: verilog/spi_pin_edge.sv
`timescale 1ns/1ns
module spi_pin_edge (
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_sck,
   input  wire logic i_ss_n,
   output logic      o_sck_rise,
   output logic      o_sck_fall,
   output logic      o_ss_n
);
   // =====================================================
   // Pins are synchronous; one stage gives edge history
   logic sck_ff;
   logic ss_n_ff;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sck_ff  <= 1'b0;
         ss_n_ff <= 1'b1;
      end else begin
         sck_ff  <= i_sck;
         ss_n_ff <= i_ss_n;
      end
   end

   assign o_sck_rise = i_sck & ~sck_ff;
   assign o_sck_fall = ~i_sck & sck_ff;
   assign o_ss_n     = ss_n_ff;
endmodule : spi_pin_edge

// file: verilog/spi_port_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Functional notes
// R1 - Eight-bit shift register sends one bit per clock, MSB first.
// R2 - Incoming bit enters LSB of same register; byte exchanged after eight clocks.
// R3 - Output changes on configured edge; input captured on the opposite edge.
// R4 - Control one bits 5:0 and status bits 7:6 set role, polarity, phase, rate.
// R5 - Sample phase bit picks middle or end of data output time.
// R6 - Enable bit takes the pins; clearing it stops the port for reconfiguration.
// R7 - Full byte copies to buffer, sets buffer full and port interrupt flag.
// R8 - Buffer write loads buffer and shift register together, no transmit buffering.
// R9 - Write during shifting is dropped and sets collision flag until cleared.
// R10 - Reading the data buffer clears buffer full.
// R11 - Master starts shifting as soon as the buffer is written.
// R12 - Master receive-only keeps shifting input and loads bytes with normal flags.
// R13 - Master rate is clock over 4, 16, 64, timer over two, or reload-based.
// R14 - With edge select set, first output bit is valid before first clock edge.
// R15 - Serial clock idle level follows clock polarity bit.
// R16 - External master holds clock at idle level before slave is enabled.
// R17 - Slave shifts on external clock and flags interrupt at last bit.
// R18 - Slave keeps working in sleep; completed byte raises wake interrupt.
// R19 - Daisy-chained slave resends received bits during the next clock group.
// R20 - Overwrite enable lets buffer take new bytes while old byte unread.
// R21 - Unselected slave ignores clock and data and does not drive output.
// R22 - Master stops clock and deselects when done; one slave at a time.
// R23 - In select mode, output driven only while select low; floats mid-byte.
// R24 - Select high in select mode or enable clear resets module and bit count.
// R25 - Software keeps sample phase bit clear in slave role.
// R26 - Master holds idle clock between bytes and gives exactly eight pulses.
// R27 - Idle write with collision flag clear completes without error flags.
module spi_port_top
   import spi_port_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_sck,
   input  wire logic        i_ss_n,
   input  wire logic        i_sdi,
   input  wire logic        i_timer_two_out,
   output logic             o_sck,
   output logic             o_sck_oe,
   output logic             o_sdo,
   output logic             o_sdo_oe,
   output logic             o_port_irq_flag
);
   typedef struct packed {
      logic        input_sample_phase;
      logic        cke;
      logic        write_collision_flag;
      logic        ov;
      logic        en;
      logic        clock_idle_polarity;
      logic [3:0]  mode;
      logic        buffer_overwrite_enable;
      logic [7:0]  reload;
      logic [7:0]  dbuf;
      logic [7:0]  sr;
      logic        bf;
      logic        irq;
      logic [2:0]  cnt;
      logic        busy;
      logic        pend;
      mstate_t     ms;
      logic        sck;
      logic        sck_oe;
      logic        sdo;
      logic        sdo_oe;
      logic        ack;
      logic [31:0] rdat;
   } port_t;

   port_t q;
   port_t n;

   logic tick;
   logic rise;
   logic fall;
   logic ss_q_n;
   logic acc;
   logic wr;
   logic is_slave;
   logic ss_mode;
   logic slv_act;
   logic lead;
   logic trail;
   logic m_lead;
   logic m_trail;
   logic m_tail;
   logic late;
   logic sample_edge;
   logic out_edge;
   logic shift_now;
   logic done;
   logic buf_wr;
   logic buf_ok;
   logic [7:0] nsr;

   function automatic logic [7:0] read_mux(input logic [7:0] adr, input port_t s);
      unique case (adr)
         ADR_STATUS: read_mux = {s.input_sample_phase, s.cke, 5'h00, s.bf};
         ADR_CTRL1:  read_mux = {s.write_collision_flag, s.ov, s.en, s.clock_idle_polarity, s.mode};
         ADR_CTRL3:  read_mux = {3'h0, s.buffer_overwrite_enable, 4'h0};
         ADR_BUF:    read_mux = s.dbuf;
         ADR_RELOAD: read_mux = s.reload;
         ADR_FLAGS:  read_mux = {7'h00, s.irq};
         default:    read_mux = 8'h00;
      endcase
   endfunction : read_mux

   function automatic logic slave_mode(input logic [3:0] m);
      slave_mode = (m == MODE_SLV_SS) || (m == MODE_SLV);
   endfunction : slave_mode

   // =====================================================
   // Rate generator and pin edge history
   spi_baud_gen u_baud (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_run        (q.ms != M_IDLE),
      .i_rate_sel   (q.mode),
      .i_reload     (q.reload),
      .i_timer_tick (i_timer_two_out),
      .o_tick       (tick)
   );

   spi_pin_edge u_edge (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_sck      (i_sck),
      .i_ss_n     (i_ss_n),
      .o_sck_rise (rise),
      .o_sck_fall (fall),
      .o_ss_n     (ss_q_n)
   );

   // =====================================================
   // Next-state logic
   always_comb begin
      n        = q;
      acc      = i_wb_cyc & i_wb_stb & ~q.ack;
      wr       = acc & i_wb_we & i_wb_sel[0];
      is_slave = slave_mode(q.mode);
      ss_mode  = q.mode == MODE_SLV_SS;
      // R21 unselected slave idle
      slv_act  = q.en & is_slave & (~ss_mode | ~ss_q_n);
      m_lead   = tick & (q.ms == M_LEAD);
      m_trail  = tick & (q.ms == M_TRAIL);
      m_tail   = tick & (q.ms == M_TAIL);
      // R17 external clock edges
      lead     = is_slave ? slv_act & (q.clock_idle_polarity ? fall : rise) : m_lead;
      trail    = is_slave ? slv_act & (q.clock_idle_polarity ? rise : fall) : m_trail;
      // R5 end-of-bit sampling
      late        = ~is_slave & q.input_sample_phase;
      // R3 opposite edges
      sample_edge = q.cke ? lead : trail;
      out_edge    = q.cke ? trail : lead;
      shift_now   = (sample_edge & ~late) | ((out_edge | m_tail) & q.pend);
      // R1 R2 MSB out, LSB in
      nsr         = shift_now ? {q.sr[6:0], i_sdi} : q.sr;
      done        = (trail & (q.cnt == LAST_BIT) & ~(late & ~q.cke)) | m_tail;

      n.ack  = acc;
      n.rdat = acc ? {24'h0000_00, read_mux(i_wb_adr, q)} : q.rdat;

      // Config writes first so hardware sets below win
      if (wr) begin
         unique case (i_wb_adr)
            ADR_STATUS: begin
               // R4 phase and edge bits
               n.input_sample_phase = i_wb_dat[ST_SMP];
               n.cke = i_wb_dat[ST_CKE];
            end
            ADR_CTRL1: begin
               // R4 role, polarity, rate
               n.write_collision_flag = i_wb_dat[C1_WRITE_COLLISION_FLAG];
               n.ov   = i_wb_dat[C1_OV];
               n.en   = i_wb_dat[C1_EN];
               n.clock_idle_polarity  = i_wb_dat[C1_CKP];
               n.mode = i_wb_dat[3:0];
            end
            ADR_CTRL3:  n.buffer_overwrite_enable   = i_wb_dat[C3_BUFFER_OVERWRITE_ENABLE];
            ADR_RELOAD: n.reload = i_wb_dat[7:0];
            ADR_FLAGS:  n.irq    = i_wb_dat[FL_IRQ];
            default:    n.rdat   = q.rdat;
         endcase
      end
      // R10 read clears full
      if (acc && !i_wb_we && i_wb_adr == ADR_BUF) begin
         n.bf = 1'b0;
      end

      // Shift engine, shared by both roles
      n.sr = nsr;
      if (sample_edge & late) begin
         n.pend = 1'b1;
      end else if (shift_now) begin
         n.pend = 1'b0;
      end
      if (out_edge) begin
         n.sdo = nsr[7];
      end
      if (lead | trail) begin
         n.busy = 1'b1;
      end
      if (trail) begin
         n.cnt = q.cnt + 3'h1;
      end
      // R26 eight pulses, idle between bytes
      if (m_lead) begin
         n.sck = ~q.clock_idle_polarity;
         n.ms  = M_TRAIL;
      end else if (m_trail) begin
         n.sck = q.clock_idle_polarity;
         if (q.cnt != LAST_BIT) begin
            n.ms = M_LEAD;
         end else begin
            n.ms = (late & ~q.cke) ? M_TAIL : M_IDLE;
         end
      end else if (m_tail) begin
         n.ms = M_IDLE;
      end
      // R7 R12 R17 R18 byte complete
      if (done) begin
         n.busy = 1'b0;
         n.cnt  = '0;
         n.bf   = 1'b1;
         n.irq  = 1'b1;
         // R20 overwrite only when allowed
         if (!q.bf || q.buffer_overwrite_enable) begin
            n.dbuf = nsr;
         end else begin
            n.ov = 1'b1;
         end
         // R19 received byte stays in shift register for next group
         n.sr = nsr;
      end

      buf_wr = wr & (i_wb_adr == ADR_BUF);
      // R9 collision while shifting or flagged
      buf_ok = ~(q.busy | q.write_collision_flag | lead | trail | done | (q.ms != M_IDLE));
      if (buf_wr && !buf_ok) begin
         n.write_collision_flag = 1'b1;
      end
      // R8 R27 load buffer and shift register together
      if (buf_wr && buf_ok) begin
         n.dbuf = i_wb_dat[7:0];
         n.sr   = i_wb_dat[7:0];
         n.cnt  = '0;
         n.pend = 1'b0;
         // R14 first bit ahead of first edge
         if (q.cke) begin
            n.sdo = i_wb_dat[7];
         end
         // R11 master starts at once
         if (q.en && !is_slave) begin
            n.ms   = M_LEAD;
            n.busy = 1'b1;
         end
      end

      // R6 R24 disable or deselect resets the counter
      if (!q.en || (ss_mode && ss_q_n)) begin
         n.cnt  = '0;
         n.busy = 1'b0;
         n.pend = 1'b0;
         n.ms   = M_IDLE;
         if (ss_mode) begin
            n.sdo = n.sr[7];
         end
      end

      // R15 idle clock level
      if (n.ms == M_IDLE) begin
         n.sck = n.clock_idle_polarity;
      end
      // R6 R23 pin ownership
      n.sck_oe = n.en & ~slave_mode(n.mode);
      n.sdo_oe = n.en & ~((n.mode == MODE_SLV_SS) & i_ss_n);
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_wb_dat        = q.rdat;
   assign o_wb_ack        = q.ack;
   assign o_sck           = q.sck;
   assign o_sck_oe        = q.sck_oe;
   assign o_sdo           = q.sdo;
   assign o_sdo_oe        = q.sdo_oe;
   assign o_port_irq_flag = q.irq;

   // =====================================================
   // Checks
   logic [3:0] lead_seen_ff;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lead_seen_ff <= '0;
      end else if (buf_wr && buf_ok) begin
         lead_seen_ff <= '0;
      end else if (m_lead) begin
         lead_seen_ff <= lead_seen_ff + 4'h1;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   // R15 idle level
   sck_idle_a: assert property (q.ms == M_IDLE |-> o_sck == q.clock_idle_polarity) // R15
      else $error("serial clock not at idle level");
   // R26 pulse count
   eight_pulse_a: assert property (done && !is_slave |-> lead_seen_ff == BYTE_BITS) // R26
      else $error("master byte without eight clock pulses");
   // R9 collision
   write_collision_flag_set_a: assert property (buf_wr && q.busy |=> q.write_collision_flag && q.dbuf == $past(q.dbuf)) // R9
      else $error("write during shift not flagged");
   // R8 load
   buf_load_a: assert property (buf_wr && buf_ok |=> q.sr == $past(i_wb_dat[7:0]) && q.dbuf == q.sr) // R8
      else $error("buffer and shift register not loaded together");
   // R11 master start
   master_go_a: assert property (buf_wr && buf_ok && q.en && !is_slave |=> q.busy ##[1:64] o_sck != q.clock_idle_polarity) // R11
      else $error("master did not start after write");
   // R7 completion
   done_flags_a: assert property (done |=> q.bf && q.irq && !q.busy) // R7
      else $error("byte completion flags missing");
   // R10 read clear
   bf_clear_a: assert property (acc && !i_wb_we && i_wb_adr == ADR_BUF && !done |=> !q.bf) // R10
      else $error("buffer full not cleared by read");
   // R24 reset on disable
   disable_reset_a: assert property (!q.en |=> q.cnt == 3'h0 && !q.busy && q.ms == M_IDLE) // R24
      else $error("disable did not reset port");
   // R23 float when deselected
   ss_float_a: assert property (q.mode == MODE_SLV_SS && i_ss_n |=> !o_sdo_oe) // R23
      else $error("output driven while deselected");
   // R14 first bit early
   cke_first_a: assert property (buf_wr && buf_ok && q.cke |=> o_sdo == $past(i_wb_dat[7])) // R14
      else $error("first bit not valid before clock");

   master_byte_c: cover property (done && !is_slave);
   slave_byte_c:  cover property (done && is_slave);
   collision_c:   cover property (buf_wr && !buf_ok);
   late_tail_c:   cover property (m_tail);
endmodule : spi_port_top

// file: tb/spi_far_model.sv
`timescale 1ns/1ns
module spi_far_model (
   input  wire logic i_core_clk,
   input  wire logic i_master,
   input  wire logic i_dut_sck,
   input  wire logic i_dut_sdo,
   output logic      o_sck,
   output logic      o_ss_n,
   output logic      o_sdi
);
   logic [7:0] sr_ff;
   logic       bit_ff;
   logic       sck_w;

   // ======================================
   // Shift register
   assign sck_w = i_master ? o_sck : i_dut_sck;
   initial begin
      o_sck  = 1'b0;
      o_ss_n = 1'b1;
      sr_ff  = 8'h00;
      bit_ff = 1'b0;
   end
   always @(posedge sck_w) begin
      bit_ff <= i_dut_sdo;
   end
   always @(negedge sck_w) begin
      sr_ff <= {sr_ff[6:0], bit_ff};
   end
   assign o_sdi = (i_master && o_ss_n) ? ~sr_ff[7] : sr_ff[7];

   // ======================================
   // Master side, four core clocks per phase
   task automatic xfer(input logic [7:0] v, input int nb, output logic [7:0] q);
      @(posedge i_core_clk);
      sr_ff  <= v;
      o_ss_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         repeat (4) @(posedge i_core_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_core_clk);
         o_sck <= 1'b0;
      end
      repeat (4) @(posedge i_core_clk);
      o_ss_n <= 1'b1;
      q = sr_ff;
   endtask : xfer
endmodule : spi_far_model

// file: tb/spi_port_top_tb.sv
`timescale 1ns/1ns
module spi_port_top_tb
   import spi_port_pkg::*;
();
   logic        clk        = 1'b0;
   logic        rst        = 1'b1;
   logic        cyc        = 1'b0;
   logic        stb        = 1'b0;
   logic        we         = 1'b0;
   logic [7:0]  adr        = 8'h00;
   logic [31:0] wdat       = 32'h0000_0000;
   logic        tmr        = 1'b0;
   logic [2:0]  tcnt       = 3'h0;
   logic        far_master = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        sck_m;
   logic        sck_oe;
   logic        sdo;
   logic        sdo_oe;
   logic        irq;
   logic        f_sck;
   logic        f_ss_n;
   logic        f_sdi;
   logic [7:0]  rx;
   int          mismatches = 0;
   int          compares   = 0;
   int          pulses     = 0;

   always #5 clk = ~clk;
   // Timer pulse every five clocks
   always @(posedge clk) begin
      tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
      tmr  <= (tcnt == 3'h4);
   end
   always @(posedge sck_m) begin
      pulses++;
   end

   spi_port_top i_spi_port_top (
      .i_core_clk      (clk),
      .i_sys_rst       (rst),
      .i_wb_cyc        (cyc),
      .i_wb_stb        (stb),
      .i_wb_we         (we),
      .i_wb_adr        (adr),
      .i_wb_sel        (4'h1),
      .i_wb_dat        (wdat),
      .o_wb_dat        (rdat),
      .o_wb_ack        (ack),
      .i_sck           (f_sck),
      .i_ss_n          (f_ss_n),
      .i_sdi           (f_sdi),
      .i_timer_two_out (tmr),
      .o_sck           (sck_m),
      .o_sck_oe        (sck_oe),
      .o_sdo           (sdo),
      .o_sdo_oe        (sdo_oe),
      .o_port_irq_flag (irq)
   );

   spi_far_model i_spi_far_model (
      .i_core_clk (clk),
      .i_master   (far_master),
      .i_dut_sck  (sck_m),
      .i_dut_sdo  (sdo_oe ? sdo : 1'b1),
      .o_sck      (f_sck),
      .o_ss_n     (f_ss_n),
      .o_sdi      (f_sdi)
   );

   // ======================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp);
      chk(got[7:0], exp[7:0]);
   endtask : chk_n

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) chk({7'h00, ack}, 8'h01);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rchk

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, irq}, 8'h01);
   endtask : wait_irq

   // ======================================
   // Scenarios
   task automatic t_regs();
      rchk(ADR_STATUS, RST_STATUS);
      rchk(ADR_CTRL1, RST_CTRL1);
      rchk(ADR_CTRL3, RST_CTRL3);
      rchk(ADR_RELOAD, RST_RELOAD);
      wr(ADR_STATUS, 8'hFF);
      rchk(ADR_STATUS, 8'hC0);
      wr(ADR_STATUS, 8'h00);
      wr(8'h18, 8'hFF);
      rchk(8'h18, 8'h00);
      $display("regs test done");
   endtask : t_regs

   task automatic t_master();
      wr(ADR_STATUS, 8'h40);
      wr(ADR_CTRL1, 8'h20);
      chk({6'h00, sck_oe, sck_m}, 8'h02);
      pulses = 0;
      wr(ADR_BUF, 8'hA5);
      chk({6'h00, sdo, sck_m}, 8'h02);
      wr(ADR_BUF, 8'h11);
      wait_irq();
      chk_n(pulses, 8);
      chk(i_spi_far_model.sr_ff, 8'hA5);
      rchk(ADR_CTRL1, 8'hA0);
      rchk(ADR_STATUS, 8'h41);
      rchk(ADR_BUF, 8'h00);
      rchk(ADR_STATUS, 8'h40);
      wr(ADR_FLAGS, 8'h00);
      wr(ADR_BUF, 8'h33);
      repeat (40) @(posedge clk);
      chk_n(pulses, 8);
      wr(ADR_CTRL1, 8'h20);
      wr(ADR_BUF, 8'h33);
      wait_irq();
      chk_n(pulses, 16);
      rchk(ADR_CTRL1, 8'h20);
      rchk(ADR_BUF, 8'hA5);
      wr(ADR_FLAGS, 8'h00);
      $display("master test done");
   endtask : t_master

   task automatic t_rates();
      logic [3:0] m [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TMR, MODE_RELOAD};
      int         h [5] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 5, 6};
      int         n;
      logic [7:0] q;
      wr(ADR_CTRL1, 8'h00);
      wr(ADR_CTRL1, 8'h30);
      chk({7'h00, sck_m}, 8'h01);
      wr(ADR_RELOAD, 8'h02);
      for (int i = 0; i < 5; i++) begin
         wr(ADR_CTRL1, 8'h00);
         wr(ADR_CTRL1, {4'h2, m[i]});
         wr(ADR_BUF, 8'h96);
         n = 0;
         while (sck_m !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         n = 0;
         while (sck_m === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         chk_n(n, h[i]);
         wait_irq();
         wr(ADR_FLAGS, 8'h00);
         wb(1'b0, ADR_BUF, 8'h00, q);
      end
      $display("rates test done");
   endtask : t_rates

   task automatic t_slave();
      wr(ADR_CTRL1, 8'h00);
      far_master = 1'b1;
      wr(ADR_STATUS, 8'h40);
      wr(ADR_CTRL1, 8'h24);
      wr(ADR_BUF, 8'hC3);
      wr(ADR_FLAGS, 8'h00);
      chk({7'h00, sdo_oe}, 8'h00);
      i_spi_far_model.xfer(8'h3C, 8, rx);
      chk(rx, 8'hC3);
      wait_irq();
      i_spi_far_model.xfer(8'h96, 8, rx);
      chk(rx, 8'h3C);
      rchk(ADR_CTRL1, 8'h64);
      wr(ADR_CTRL3, 8'h10);
      i_spi_far_model.xfer(8'h69, 8, rx);
      rchk(ADR_BUF, 8'h69);
      i_spi_far_model.xfer(8'hFF, 3, rx);
      repeat (2) @(posedge clk);
      chk({7'h00, sdo_oe}, 8'h00);
      i_spi_far_model.xfer(8'hB4, 8, rx);
      rchk(ADR_BUF, 8'hB4);
      wr(ADR_CTRL1, 8'h00);
      wr(ADR_CTRL1, 8'h25);
      wr(ADR_BUF, 8'h5A);
      i_spi_far_model.xfer(8'h0F, 8, rx);
      chk(rx, 8'h5A);
      rchk(ADR_BUF, 8'h0F);
      $display("slave test done");
   endtask : t_slave

   // ======================================
   // Verdict
   task automatic finish_test();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_master();
      t_rates();
      t_slave();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test();
   end
endmodule : spi_port_top_tb
